// File: gang_irq_monitor.sv
// Purpose: Port-level checks for the gang drive and pin interrupt block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the top module at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module gang_irq_monitor
    import gang_irq_pkg::*;
(
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic [1:0]       s_axi_bresp,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire logic [31:0]      s_axi_rdata,
    input wire pin_src_t [7:0]   pin_src,
    input wire pin_drive_t [7:0] gang_pin,
    input wire logic [1:0]       port_irq,
    input wire logic             wake_request,
    input wire logic             partial_power_down,
    input wire logic             io_hold
);
    // ----
    // Checks
    // ----
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_wake_tracks_irq: assert property (wake_request == (|port_irq))
        else $error("wake differs from port requests");
    chk_hold_entry: assert property (partial_power_down |=> io_hold)
        else $error("no hold in power-down");
    chk_hold_freeze: assert property (io_hold && $past(io_hold) |-> $stable(gang_pin))
        else $error("pins moved while held");
    for (genvar i = 0; i < 8; i++) begin : g_pin
        chk_analog_wins: assert property (pin_src[i].analog && !io_hold
            |=> gang_pin[i].oe_n && !gang_pin[i].out)
            else $error("analog pin still driven");
    end
    chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    chk_write_answer: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready) == 1'h0 && $past(s_axi_wready) == 1'h0)
        else $error("response before both taken");
endmodule : gang_irq_monitor
bind port_gang_and_pin_interrupt gang_irq_monitor mon (.*);
`default_nettype wire

// File: gang_irq_pkg.sv
// Purpose: Shared constants and types for the gang drive and pin interrupt block
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
package gang_irq_pkg;

    // ----
    // Register offsets
    // ----
    localparam logic [7:0] ADDR_GANG      = 8'h00;
    localparam logic [7:0] ADDR_PC0       = 8'h04;
    localparam logic [7:0] ADDR_PIN_LEVEL = 8'h30;
    localparam logic [7:0] ADDR_POWER     = 8'h34;
    localparam logic [7:0] PORT_BASE [2]  = '{8'h10, 8'h20};
    localparam logic [7:0] SUB_ENABLE     = 8'h00;
    localparam logic [7:0] SUB_POLARITY   = 8'h04;
    localparam logic [7:0] SUB_PULL       = 8'h08;
    localparam logic [7:0] SUB_STATUS     = 8'h0c;

    // ----
    // Field positions
    // ----
    localparam int GANG_EN_BIT = 0;
    localparam int PC0_DATA    = 0;
    localparam int PC0_DRIVE   = 1;
    localparam int PC0_SLEW    = 2;
    localparam int PC0_DIR     = 3;
    localparam int SC_MODE     = 0;
    localparam int SC_IE       = 1;
    localparam int SC_ACK      = 2;
    localparam int SC_FLAG     = 3;
    localparam int PWR_ACK     = 2;
    localparam int PWR_FLAG    = 3;

    // ----
    // Reset values and responses
    // ----
    localparam logic [7:0] GANG_RESET = 8'h00;
    localparam logic [3:0] PC0_RESET  = 4'h0;
    localparam logic [3:0] IRQ_RESET  = 4'h0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----
    // Types
    // ----
    typedef struct packed {
        logic out;
        logic drive;
        logic slew;
        logic oe_n;
    } pin_drive_t;

    typedef struct packed {
        logic analog;
        logic digital;
        logic dig_out;
        logic dig_oe;
        logic gpio_out;
        logic gpio_dir;
        logic drive;
        logic slew;
    } pin_src_t;

    typedef struct packed {
        logic [3:0] enable;
        logic [3:0] polarity;
        logic [3:0] pull;
        logic       mode;
        logic       ie;
    } port_irq_cfg_t;

endpackage : gang_irq_pkg

// File: pin_irq_port.sv
// Purpose: Pin interrupt detection for one port
// Assumes: pin_raw is asynchronous to aclk
// Notes:   Flag is sticky; acknowledge is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module pin_irq_port
    import gang_irq_pkg::*;
#(
    parameter int PINS = 4
) (
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic [PINS-1:0] pin_raw,
    input  wire logic [PINS-1:0] enable,
    input  wire logic [PINS-1:0] polarity,
    input  wire logic            mode,
    input  wire logic            ack,
    output logic                 flag,
    output logic      [PINS-1:0] level
);

    if (PINS < 1 || PINS > 4) begin : g_check
        $error("PINS must be 1 to 4");
    end

    logic [PINS-1:0] sync1;
    logic [PINS-1:0] sync2;
    logic [PINS-1:0] sync3;
    logic [PINS-1:0] prev;
    logic [PINS-1:0] active;
    logic [PINS-1:0] edge_hit;
    logic [PINS-1:0] already;
    logic            set_flag;
    logic            clr_flag;

    // ----
    // Synchroniser and filter
    // ----
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Level moves only when two stages agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level <= '0;
        end else begin
            for (int i = 0; i < PINS; i++) begin
                if (sync2[i] == sync3[i]) begin
                    level[i] <= sync3[i];
                end
            end
        end
    end

    // ----
    // Detection
    // ----
    always_comb begin
        active   = enable & ~(level ^ polarity);
        edge_hit = active & ~prev;
        already  = active & prev;
        if (mode) begin
            set_flag = |active;
        end else begin
            set_flag = (|edge_hit) && !(|already);
        end
        clr_flag = ack && (!mode || !(|active));
    end

    // Disabled pins look asserted, so a deasserted sample must come first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev <= '1;
        end else begin
            prev <= active | ~enable;
        end
    end

    // Set wins over acknowledge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag <= 1'b0;
        end else if (set_flag) begin
            flag <= 1'b1;
        end else if (clr_flag) begin
            flag <= 1'b0;
        end
    end

endmodule : pin_irq_port
`default_nettype wire

// File: pin_partner.sv
// Purpose: External pins feeding the pin interrupt inputs
// Assumes: Pull settings come from the block outputs
// Notes:   An undriven, unpulled pin wanders every cycle
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
    input  wire logic [7:0] drive_en,
    input  wire logic [7:0] drive_val,
    input  wire logic [7:0] pull_enable,
    input  wire logic [7:0] pull_down,
    input  wire logic       aclk,
    output logic      [3:0] irq_pin_a,
    output logic      [3:0] irq_pin_b
);
    logic [7:0] wander = 8'h00;
    always_ff @(posedge aclk) wander <= ~wander;
    // Released pin settles to its pull
    assign {irq_pin_b, irq_pin_a} = (drive_en & drive_val) | (~drive_en & pull_enable & ~pull_down)
        | (~drive_en & ~pull_enable & wander);
endmodule : pin_partner
`default_nettype wire

// File: port_gang_and_pin_interrupt.sv
// Purpose: Ganged output drive, port A/B pin interrupts and stop-mode I/O hold
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes:   Pin outputs are registered; hold freezes them
`timescale 1ns/100ps
`default_nettype none
module port_gang_and_pin_interrupt
    import gang_irq_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire pin_src_t [7:0]    pin_src,
    output var pin_drive_t [7:0]   gang_pin,
    input  wire logic [3:0]        irq_pin_a,
    input  wire logic [3:0]        irq_pin_b,
    output logic [7:0]             pull_enable,
    output logic [7:0]             pull_down,
    output logic [1:0]             port_irq,
    output logic                   wake_request,
    input  wire logic              partial_power_down,
    input  wire logic              power_down_recovered,
    output logic                   io_hold
);

    if (ADDR_W < 8 || ADDR_W > 32) begin : g_check
        $error("ADDR_W must be 8 to 32");
    end

    // ----
    // Declarations
    // ----
    logic [7:0]    ganged_drive_control;
    logic          gang_written;
    logic [3:0]    pc0;
    port_irq_cfg_t cfg [2];
    logic [1:0]    flag;
    logic [3:0]    level_a;
    logic [3:0]    level_b;
    logic          power_down_recovered_flag;
    logic          aw_full;
    logic          w_full;
    logic [7:0]    wr_addr;
    logic [31:0]   wr_data;
    logic          wr_strb0;
    logic          do_write;
    logic          wr_hit;
    logic          wr_io;
    logic          wr_ok;
    logic [1:0]    port_ack;
    logic          power_down_acknowledge;
    logic [7:0]    rd_addr;
    logic [31:0]   rd_value;
    logic          rd_hit;
    logic          next_aw_full;
    logic          next_w_full;

    // ------------------------------------------------------------
    // AXI write channels
    // ------------------------------------------------------------
    assign do_write = aw_full && w_full && !s_axi_bvalid;

    always_comb begin
        next_aw_full = aw_full;
        next_w_full  = w_full;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
        end else if (do_write) begin
            next_aw_full = 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
        end else if (do_write) begin
            next_w_full = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            wr_addr       <= '0;
            wr_data       <= '0;
            wr_strb0      <= 1'b0;
        end else begin
            aw_full       <= next_aw_full;
            w_full        <= next_w_full;
            s_axi_awready <= !next_aw_full;
            s_axi_wready  <= !next_w_full;
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data  <= s_axi_wdata;
                wr_strb0 <= s_axi_wstrb[0];
            end
        end
    end

    always_comb begin
        wr_hit = 1'b1;
        wr_io  = 1'b1;
        case (wr_addr)
            ADDR_GANG, ADDR_PC0: wr_io = 1'b1;
            PORT_BASE[0] + SUB_ENABLE, PORT_BASE[0] + SUB_POLARITY,
            PORT_BASE[0] + SUB_PULL, PORT_BASE[0] + SUB_STATUS,
            PORT_BASE[1] + SUB_ENABLE, PORT_BASE[1] + SUB_POLARITY,
            PORT_BASE[1] + SUB_PULL, PORT_BASE[1] + SUB_STATUS: wr_io = 1'b1;
            ADDR_PIN_LEVEL, ADDR_POWER: wr_io = 1'b0;
            default: begin
                wr_hit = 1'b0;
                wr_io  = 1'b0;
            end
        endcase
        // I/O writes refused until the hold is acknowledged
        wr_ok = do_write && wr_hit && wr_strb0 && !(wr_io && io_hold);
        for (int p = 0; p < 2; p++) begin
            port_ack[p] = wr_ok && wr_addr == PORT_BASE[p] + SUB_STATUS && wr_data[SC_ACK];
        end
        power_down_acknowledge = wr_ok && wr_addr == ADDR_POWER && wr_data[PWR_ACK];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (!wr_hit || (wr_io && io_hold)) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Write-once: later writes are answered but dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ganged_drive_control <= GANG_RESET;
            gang_written         <= 1'b0;
        end else if (wr_ok && wr_addr == ADDR_GANG && !gang_written) begin
            ganged_drive_control <= wr_data[7:0];
            gang_written         <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc0 <= PC0_RESET;
        end else if (wr_ok && wr_addr == ADDR_PC0) begin
            pc0 <= wr_data[3:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int p = 0; p < 2; p++) begin
                cfg[p] <= '{IRQ_RESET, IRQ_RESET, IRQ_RESET, 1'b0, 1'b0};
            end
        end else if (wr_ok) begin
            for (int p = 0; p < 2; p++) begin
                if (wr_addr == PORT_BASE[p] + SUB_ENABLE) begin
                    cfg[p].enable <= wr_data[3:0];
                end
                if (wr_addr == PORT_BASE[p] + SUB_POLARITY) begin
                    cfg[p].polarity <= wr_data[3:0];
                end
                if (wr_addr == PORT_BASE[p] + SUB_PULL) begin
                    cfg[p].pull <= wr_data[3:0];
                end
                if (wr_addr == PORT_BASE[p] + SUB_STATUS) begin
                    cfg[p].mode <= wr_data[SC_MODE];
                    cfg[p].ie   <= wr_data[SC_IE];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Stop-mode hold and recovery
    // ------------------------------------------------------------
    // Partial power-down sets the hold; I/O resumes only after the acknowledge write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io_hold <= 1'b0;
        end else if (partial_power_down) begin
            io_hold <= 1'b1;
        end else if (power_down_acknowledge) begin
            io_hold <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_down_recovered_flag <= 1'b0;
        end else if (power_down_recovered) begin
            power_down_recovered_flag <= 1'b1;
        end else if (power_down_acknowledge) begin
            power_down_recovered_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin interrupt ports
    // ------------------------------------------------------------
    pin_irq_port #(
        .PINS (4)
    ) u_port_a (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin_raw  (irq_pin_a),
        .enable   (cfg[0].enable),
        .polarity (cfg[0].polarity),
        .mode     (cfg[0].mode),
        .ack      (port_ack[0]),
        .flag     (flag[0]),
        .level    (level_a)
    );

    pin_irq_port #(
        .PINS (4)
    ) u_port_b (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin_raw  (irq_pin_b),
        .enable   (cfg[1].enable),
        .polarity (cfg[1].polarity),
        .mode     (cfg[1].mode),
        .ack      (port_ack[1]),
        .flag     (flag[1]),
        .level    (level_b)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_irq     <= 2'h0;
            wake_request <= 1'b0;
            pull_enable  <= 8'h00;
            pull_down    <= 8'h00;
        end else begin
            port_irq     <= flag & {cfg[1].ie, cfg[0].ie};
            wake_request <= |(flag & {cfg[1].ie, cfg[0].ie});
            pull_enable  <= {cfg[1].pull, cfg[0].pull};
            pull_down    <= {cfg[1].polarity, cfg[0].polarity};
        end
    end

    // ------------------------------------------------------------
    // Pin output selection
    // ------------------------------------------------------------
    // Bit 0 of the gang register is the enable and also selects C0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 8; i++) begin
                gang_pin[i] <= '{1'b0, 1'b0, 1'b0, 1'b1};
            end
        end else if (!io_hold) begin
            for (int i = 0; i < 8; i++) begin
                if (pin_src[i].analog) begin
                    gang_pin[i] <= '{1'b0, 1'b0, 1'b0, 1'b1};
                end else if (ganged_drive_control[GANG_EN_BIT] && ganged_drive_control[i]) begin
                    gang_pin[i] <= '{pc0[PC0_DATA], pc0[PC0_DRIVE], pc0[PC0_SLEW], 1'b0};
                end else if (pin_src[i].digital) begin
                    gang_pin[i] <= '{pin_src[i].dig_out, pin_src[i].drive,
                                     pin_src[i].slew, !pin_src[i].dig_oe};
                end else if (i == 0) begin
                    gang_pin[i] <= '{pc0[PC0_DATA], pc0[PC0_DRIVE], pc0[PC0_SLEW], !pc0[PC0_DIR]};
                end else begin
                    gang_pin[i] <= '{pin_src[i].gpio_out, pin_src[i].drive,
                                     pin_src[i].slew, !pin_src[i].gpio_dir};
                end
            end
        end
    end

    // ----
    // AXI read channel
    // ----
    assign rd_addr = {s_axi_araddr[7:2], 2'b00};

    always_comb begin
        rd_value = 32'h0000_0000;
        rd_hit   = 1'b1;
        case (rd_addr)
            ADDR_GANG:      rd_value[7:0] = ganged_drive_control;
            ADDR_PC0:       rd_value[3:0] = pc0;
            ADDR_PIN_LEVEL: rd_value[7:0] = {level_b, level_a};
            ADDR_POWER:     rd_value[PWR_FLAG] = power_down_recovered_flag;
            default: begin
                rd_hit = 1'b0;
                for (int p = 0; p < 2; p++) begin
                    if (rd_addr == PORT_BASE[p] + SUB_ENABLE) begin
                        rd_value[3:0] = cfg[p].enable;
                        rd_hit        = 1'b1;
                    end
                    if (rd_addr == PORT_BASE[p] + SUB_POLARITY) begin
                        rd_value[3:0] = cfg[p].polarity;
                        rd_hit        = 1'b1;
                    end
                    if (rd_addr == PORT_BASE[p] + SUB_PULL) begin
                        rd_value[3:0] = cfg[p].pull;
                        rd_hit        = 1'b1;
                    end
                    if (rd_addr == PORT_BASE[p] + SUB_STATUS) begin
                        rd_value[SC_MODE] = cfg[p].mode;
                        rd_value[SC_IE]   = cfg[p].ie;
                        rd_value[SC_FLAG] = flag[p];
                        rd_hit            = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_value;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule : port_gang_and_pin_interrupt
`default_nettype wire

// File: port_gang_and_pin_interrupt_tb.sv
// Purpose: Self-checking bench for the gang drive and pin interrupt block
// Assumes: One 100 MHz clock, synchronous active-low reset
// Notes:   Reset checks, then register rows, then hand-written cases
`timescale 1ns/100ps
`default_nettype none
module port_gang_and_pin_interrupt_tb
    import gang_irq_pkg::*;
;
    logic             aclk = 1'h0, aresetn = 1'h0;
    logic       [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, ext_en = '0, ext_val = '0;
    logic      [31:0] s_axi_wdata = '0, s_axi_rdata, got;
    logic             s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = 1'h1, s_axi_arvalid = '0;
    logic             s_axi_rready = 1'h1, partial_power_down = '0, power_down_recovered = '0;
    logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_request, io_hold;
    logic       [1:0] s_axi_bresp, s_axi_rresp, port_irq, resp;
    logic       [3:0] irq_pin_a, irq_pin_b;
    logic       [7:0] pull_enable, pull_down;
    pin_src_t   [7:0] pin_src = '0;
    pin_drive_t [7:0] gang_pin;
    int               failures = 0, samples_checked = 0, cycles = 0;
    typedef struct packed { logic [7:0] a; logic [31:0] d; logic [31:0] r; logic [1:0] e; } row_t;
    localparam row_t ROWS [6] = '{'{8'h04, 32'h3, 32'h3, RESP_OKAY}, '{8'h14, 32'h0, 32'h0, RESP_OKAY},
        '{8'h18, 32'hf, 32'hf, RESP_OKAY}, '{8'h24, 32'hf, 32'hf, RESP_OKAY},
        '{8'h28, 32'hf, 32'hf, RESP_OKAY}, '{8'h3c, 32'h5, 32'h0, RESP_SLVERR}};
    always #5 aclk = ~aclk;
    port_gang_and_pin_interrupt DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_src, .gang_pin, .irq_pin_a, .irq_pin_b, .pull_enable,
        .pull_down, .port_irq, .wake_request, .partial_power_down, .power_down_recovered, .io_hold);
    pin_partner pins (.drive_en(ext_en), .drive_val(ext_val), .pull_enable, .pull_down, .aclk,
        .irq_pin_a, .irq_pin_b);
    // ----
    // Tasks
    // ----
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        resp = s_axi_bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        got = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : rd
    task automatic settle;
        repeat (10) @(posedge aclk);
    endtask : settle
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            final_report;
        end
    end
    // ----
    // Sequence
    // ----
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        check("gang_pin reset", 32'(gang_pin), 32'h11111111);
        rd(ADDR_GANG);
        check("gang reset", got, 32'h0);
        $display("reset test done");
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].d);
            check("row wresp", 32'(resp), 32'(ROWS[i].e));
            rd(ROWS[i].a);
            check("row rdata", got, ROWS[i].r);
            check("row rresp", 32'(resp), 32'(ROWS[i].e));
        end
        $display("register rows done");
        pin_src[3].digital <= 1'h1;
        pin_src[3].dig_oe <= 1'h1;
        wr(ADDR_GANG, 32'h89);
        settle;
        check("gang c0", 32'(gang_pin[0]), 32'hc);
        check("gang b5", 32'(gang_pin[7]), 32'hc);
        check("gang c3", 32'(gang_pin[3]), 32'hc);
        check("unselected", 32'(gang_pin[6].oe_n), 32'h1);
        wr(ADDR_GANG, 32'h0);
        rd(ADDR_GANG);
        check("write once", got, 32'h89);
        pin_src[7].analog <= 1'h1;
        settle;
        check("analog", 32'({gang_pin[7].out, gang_pin[7].oe_n}), 32'h1);
        $display("gang test done");
        wr(8'h1c, 32'h0);
        wr(8'h10, 32'h3);
        wr(8'h1c, 32'h4);
        wr(8'h1c, 32'h2);
        ext_en <= 8'h04;
        settle;
        check("disabled pin", 32'(port_irq), 32'h0);
        ext_en <= 8'h05;
        settle;
        check("falling edge", 32'(port_irq), 32'h1);
        rd(ADDR_PIN_LEVEL);
        check("pin levels", got, 32'h0a);
        wr(8'h1c, 32'h6);
        settle;
        check("edge ack", 32'(port_irq), 32'h0);
        ext_en <= 8'h07;
        settle;
        check("edge masked", 32'(port_irq), 32'h0);
        ext_en <= 8'h00;
        check("pull sense", 32'(pull_down), 32'hf0);
        wr(8'h2c, 32'h0);
        wr(8'h20, 32'h1);
        wr(8'h2c, 32'h5);
        wr(8'h2c, 32'h3);
        ext_val <= 8'h10;
        ext_en <= 8'h10;
        settle;
        check("level set", 32'(port_irq), 32'h2);
        wr(8'h2c, 32'h7);
        settle;
        check("ack refused", 32'(port_irq), 32'h2);
        ext_en <= 8'h00;
        settle;
        wr(8'h2c, 32'h7);
        settle;
        check("ack taken", 32'(port_irq), 32'h0);
        $display("pin interrupt tests done");
        partial_power_down <= 1'h1;
        settle;
        check("hold", 32'(io_hold), 32'h1);
        pin_src[6].gpio_dir <= 1'h1;
        wr(ADDR_PC0, 32'h0);
        check("refused", 32'(resp), 32'(RESP_SLVERR));
        check("frozen", 32'(gang_pin[6].oe_n), 32'h1);
        power_down_recovered <= 1'h1;
        partial_power_down <= 1'h0;
        @(posedge aclk);
        power_down_recovered <= 1'h0;
        rd(ADDR_POWER);
        check("recovered", got, 32'h8);
        check("held", 32'(io_hold), 32'h1);
        wr(ADDR_POWER, 32'h4);
        settle;
        check("released", 32'(io_hold), 32'h0);
        check("resumed", 32'(gang_pin[6].oe_n), 32'h0);
        check("pins kept", 32'(gang_pin[0]), 32'hc);
        rd(ADDR_POWER);
        check("flag cleared", got, 32'h0);
        $display("power test done");
        final_report;
    end
endmodule : port_gang_and_pin_interrupt_tb
`default_nettype wire
